// File: design/tdb_divider.sv
`timescale 1ns/1ps
module tdb_divider #(
  parameter int NUM_W = 48,
  parameter int DEN_W = 32
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic start_i, // Start num_i / den_i
  input wire logic [NUM_W-1:0] num_i, // Dividend
  input wire logic [DEN_W-1:0] den_i, // Divisor, nonzero
  output logic busy_o, // Division in progress
  output logic done_o, // Quotient ready pulse
  output logic [NUM_W-1:0] quot_o // Quotient
);

  logic [NUM_W-1:0] q;
  logic [DEN_W:0] rem;
  logic [DEN_W-1:0] den;
  logic [$clog2(NUM_W+1)-1:0] cnt;
  logic [DEN_W:0] shifted;
  logic fits;

  // One quotient bit per cycle, restoring
  assign shifted = {rem[DEN_W-1:0], q[NUM_W-1]};
  assign fits = shifted >= {1'b0, den};

  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy_o <= 1'b0;
      q <= '0;
      rem <= '0;
      den <= '0;
      cnt <= '0;
      quot_o <= '0;
    end else if (start_i) begin
      busy_o <= 1'b1;
      q <= num_i;
      rem <= '0;
      den <= den_i;
      cnt <= $bits(cnt)'(NUM_W);
    end else if (busy_o) begin
      rem <= fits ? shifted - {1'b0, den} : shifted;
      q <= {q[NUM_W-2:0], fits};
      cnt <= cnt - 1'b1;
      if (cnt == 1) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
        quot_o <= {q[NUM_W-2:0], fits};
      end
    end
  end

endmodule

// File: design/tdb_isqrt.sv
`timescale 1ns/1ps
module tdb_isqrt #(
  parameter int IN_W = 32
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset
  input wire logic start_i, // Start root of rad_i
  input wire logic [IN_W-1:0] rad_i, // Radicand
  output logic busy_o, // Root in progress
  output logic done_o, // Result ready pulse
  output logic [IN_W/2-1:0] root_o // Integer root
);

  localparam int OW = IN_W / 2;
  logic [IN_W-1:0] rem;
  logic [IN_W-1:0] bitv;
  logic [IN_W-1:0] acc;
  logic [IN_W-1:0] trial;
  logic ge;

  // Trial subtraction for restoring square root
  assign trial = acc + bitv;
  assign ge = rem >= trial;

  // Bit-serial root, two radicand bits per cycle
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy_o <= 1'b0;
      rem <= '0;
      bitv <= '0;
      acc <= '0;
      root_o <= '0;
    end else if (start_i) begin
      busy_o <= 1'b1;
      rem <= rad_i;
      acc <= '0;
      bitv <= {2'b01, {(IN_W-2){1'b0}}};
    end else if (busy_o) begin
      if (ge) begin
        rem <= rem - trial;
        acc <= (acc >> 1) + bitv;
      end else begin
        acc <= acc >> 1;
      end
      bitv <= bitv >> 2;
      if (bitv[0]) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
        root_o <= OW'(ge ? (acc >> 1) + bitv : acc >> 1);
      end
    end
  end

endmodule

// File: design/tdb_pkg.sv
package tdb_pkg;

  // ****************************************************************
  // Register map (Wishbone byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DET = 8'h04;
  localparam logic [7:0] ADDR_SPAN_START = 8'h08;
  localparam logic [7:0] ADDR_SPAN_STOP = 8'h0C;
  localparam logic [7:0] ADDR_LEVEL_RANGE = 8'h10;
  localparam logic [7:0] ADDR_ZOOM = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MEAS_CYC = 8'h1C;
  localparam logic [7:0] ADDR_VFB = 8'h20;
  localparam logic [7:0] ADDR_MEAS_CNT = 8'h24;
  localparam logic [7:0] ADDR_TRACE_BASE = 8'h40;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_AUTO_POS = 0;
  localparam int CTRL_ZOOM_POS = 0;
  localparam int MODE_W = 3;
  localparam int DET_W = 3;
  localparam int PATHS = 6;
  localparam int TRACES = 3;
  localparam logic [31:0] SPAN_START_RST = 32'h0000_0000;
  localparam logic [31:0] SPAN_STOP_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] LEVEL_RANGE_RST = 32'h0000_FFFF;
  localparam logic [31:0] MEAS_CYC_RST = 32'h0000_0001;
  localparam logic [31:0] VFB_RST = 32'h0000_0000;

  // ****************************************************************
  // Trace modes and detector kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    TM_BLANK, TM_CLEAR_WRITE, TM_MAX_HOLD, TM_MIN_HOLD, TM_AVERAGE, TM_VIEW
  } tdb_mode_t;

  typedef enum logic [2:0] {
    DT_NONE, DT_AUTO_PEAK, DT_POS_PEAK, DT_NEG_PEAK, DT_AVERAGE, DT_RMS, DT_SAMPLE
  } tdb_det_t;

  // Sample stream beat
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [15:0] level;
  } tdb_sample_t;

  // Concurrent detector results for one point
  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] neg;
    logic [15:0] avg;
    logic [15:0] rms;
    logic [15:0] smp;
  } tdb_res_t;

endpackage

// File: design/tdb_top.sv
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// R1 - Auto selection maps trace mode to detector
// R2 - Auto peak yields both max and min
// R3 - Positive peak max, negative peak min
// R4 - Peaks hold exactly, never decay
// R5 - Average sums samples, divides by count
// R6 - RMS over configured measurement time
// R7 - Sample detector keeps first bin value
// R8 - All detectors run concurrently on stream
// R9 - Selected result written as trace point
// R10 - Each trace and path own detector; only the det_cfg fields of the three traces are used
// R11 - RMS bypasses video filter, keeps timing
// R12 - Controller should cover over ten pulses
// R13 - Zoom loads new span and level range
// R14 - Mode change clears trace memory
// R15 - Max hold stores only larger value
// R16 - Detectors reinitialized at each point start
module tdb_top #(
  parameter int LVL_W = 16,
  parameter int CNT_W = 32,
  parameter int PTS = 16
) (
  input wire logic clk_i, // Clock, 20 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire tdb_pkg::tdb_sample_t smp_i, // Video envelope sample beat
  input wire logic [LVL_W-1:0] filt_level_i, // Video-filtered level
  output logic vfilt_bypass_o, // Video filter bypassed
  output logic [31:0] meas_cycles_o, // Effective point time
  output logic [31:0] span_start_o, // Active start frequency
  output logic [31:0] span_stop_o, // Active stop frequency
  output logic [31:0] level_range_o, // Active level axis range
  output logic pt_valid_o, // Point result pulse
  output logic [$clog2(PTS)-1:0] pt_index_o, // Point index
  output tdb_pkg::tdb_res_t pt_res_o, // All detector results
  output logic [LVL_W-1:0] pt_auto_min_o // Auto peak minimum
);

  localparam int AW = $clog2(PTS);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [tdb_pkg::TRACES*tdb_pkg::MODE_W-1:0] ctrl;
  logic auto_sel;
  logic [tdb_pkg::PATHS*tdb_pkg::DET_W-1:0] det_cfg;
  logic [31:0] zoom_start;
  logic [31:0] zoom_stop;
  logic [31:0] zoom_range;
  logic [31:0] meas_cyc;
  logic [31:0] vfb;
  logic [31:0] meas_cnt;
  logic [AW-1:0] point;
  logic [LVL_W-1:0] trace_mem [tdb_pkg::TRACES][PTS];
  logic [tdb_pkg::TRACES-1:0] clr_pend;

  // Write data merged by byte selects
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    for (int b = 0; b < 4; b++) begin
      r[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    return r;
  endfunction

  // Detector effective for one path
  function automatic tdb_pkg::tdb_det_t eff_det(input logic [2:0] cfg, input logic [2:0] mode,
                                                input logic is_trace, input logic auto);
    tdb_pkg::tdb_det_t d;
    d = tdb_pkg::tdb_det_t'(cfg);
    if (auto && is_trace) begin
      case (tdb_pkg::tdb_mode_t'(mode)) // R1
        tdb_pkg::TM_CLEAR_WRITE: d = tdb_pkg::DT_AUTO_PEAK;
        tdb_pkg::TM_MAX_HOLD: d = tdb_pkg::DT_POS_PEAK;
        tdb_pkg::TM_MIN_HOLD: d = tdb_pkg::DT_NEG_PEAK;
        tdb_pkg::TM_AVERAGE: d = tdb_pkg::DT_SAMPLE;
        default: d = tdb_pkg::DT_NONE;
      endcase
    end
    return d;
  endfunction

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i;
  wire hit_trace = wb_adr_i >= tdb_pkg::ADDR_TRACE_BASE;
  wire [7:0] toff = wb_adr_i - tdb_pkg::ADDR_TRACE_BASE;
  wire [1:0] tsel = toff[7:6];
  wire [AW-1:0] tpt = toff[AW+1:2];
  wire zoom_go = bus_wr && (wb_adr_i == tdb_pkg::ADDR_ZOOM) && wb_sel_i[0]
                 && wb_dat_i[tdb_pkg::CTRL_ZOOM_POS];
  wire [31:0] ctrl_word = {{(31-tdb_pkg::TRACES*tdb_pkg::MODE_W){1'b0}}, auto_sel, ctrl};
  wire [31:0] ctrl_new = merge(ctrl_word, wb_dat_i, wb_sel_i);

  // Read multiplexer
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    if (wb_adr_i == tdb_pkg::ADDR_CTRL) begin
      rd = ctrl_word;
    end else if (wb_adr_i == tdb_pkg::ADDR_DET) begin
      rd = {{(32-tdb_pkg::PATHS*tdb_pkg::DET_W){1'b0}}, det_cfg};
    end else if (wb_adr_i == tdb_pkg::ADDR_SPAN_START) begin
      rd = zoom_start;
    end else if (wb_adr_i == tdb_pkg::ADDR_SPAN_STOP) begin
      rd = zoom_stop;
    end else if (wb_adr_i == tdb_pkg::ADDR_LEVEL_RANGE) begin
      rd = zoom_range;
    end else if (wb_adr_i == tdb_pkg::ADDR_STATUS) begin
      rd = {{(32-AW-tdb_pkg::TRACES){1'b0}}, point, clr_pend};
    end else if (wb_adr_i == tdb_pkg::ADDR_MEAS_CYC) begin
      rd = meas_cyc;
    end else if (wb_adr_i == tdb_pkg::ADDR_VFB) begin
      rd = vfb;
    end else if (wb_adr_i == tdb_pkg::ADDR_MEAS_CNT) begin
      rd = meas_cnt;
    end else if (hit_trace && tsel < 2'(tdb_pkg::TRACES)) begin
      rd = {{(32-LVL_W){1'b0}}, trace_mem[tsel][tpt]};
    end
  end

  // Registered one-cycle ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      auto_sel <= 1'b1;
      det_cfg <= '0;
      zoom_start <= tdb_pkg::SPAN_START_RST;
      zoom_stop <= tdb_pkg::SPAN_STOP_RST;
      zoom_range <= tdb_pkg::LEVEL_RANGE_RST;
      meas_cyc <= tdb_pkg::MEAS_CYC_RST;
      vfb <= tdb_pkg::VFB_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == tdb_pkg::ADDR_CTRL) begin
        ctrl <= ctrl_new[tdb_pkg::TRACES*tdb_pkg::MODE_W-1:0];
        auto_sel <= ctrl_new[tdb_pkg::TRACES*tdb_pkg::MODE_W];
      end else if (wb_adr_i == tdb_pkg::ADDR_DET) begin
        det_cfg <= (tdb_pkg::PATHS*tdb_pkg::DET_W)'(merge(32'(det_cfg), wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == tdb_pkg::ADDR_SPAN_START) begin
        zoom_start <= merge(zoom_start, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tdb_pkg::ADDR_SPAN_STOP) begin
        zoom_stop <= merge(zoom_stop, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tdb_pkg::ADDR_LEVEL_RANGE) begin
        zoom_range <= merge(zoom_range, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tdb_pkg::ADDR_MEAS_CYC) begin
        meas_cyc <= merge(meas_cyc, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tdb_pkg::ADDR_VFB) begin
        vfb <= merge(vfb, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Zoom applies staged span and level range at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      span_start_o <= tdb_pkg::SPAN_START_RST;
      span_stop_o <= tdb_pkg::SPAN_STOP_RST;
      level_range_o <= tdb_pkg::LEVEL_RANGE_RST;
    end else if (zoom_go) begin
      span_start_o <= zoom_start; // R13
      span_stop_o <= zoom_stop; // R13
      level_range_o <= zoom_range; // R13
    end
  end

  // ****************************************************************
  // Parallel detectors
  // ****************************************************************
  wire any_rms = (eff_det(det_cfg[0 +: 3], ctrl[0 +: 3], 1'b1, auto_sel) == tdb_pkg::DT_RMS)
              || (eff_det(det_cfg[3 +: 3], ctrl[3 +: 3], 1'b1, auto_sel) == tdb_pkg::DT_RMS)
              || (eff_det(det_cfg[6 +: 3], ctrl[6 +: 3], 1'b1, auto_sel) == tdb_pkg::DT_RMS);
  // Video filter bypass; filter bandwidth still lengthens point time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vfilt_bypass_o <= 1'b0;
      meas_cycles_o <= tdb_pkg::MEAS_CYC_RST;
    end else begin
      vfilt_bypass_o <= any_rms; // R11
      meas_cycles_o <= meas_cyc + vfb; // R11
    end
  end
  wire [LVL_W-1:0] lvl = vfilt_bypass_o ? smp_i.level : filt_level_i;
  wire [LVL_W-1:0] raw = smp_i.level;

  logic [LVL_W-1:0] pmax;
  logic [LVL_W-1:0] pmin;
  logic [LVL_W-1:0] first_v;
  logic got_first;
  logic [CNT_W+LVL_W-1:0] sum;
  logic [CNT_W+2*LVL_W-1:0] sumsq;
  logic [CNT_W-1:0] n;
  wire beat = smp_i.valid;
  wire st = beat && smp_i.first;
  wire [CNT_W+LVL_W-1:0] sum_f = (st ? '0 : sum) + (CNT_W+LVL_W)'(raw);
  wire [CNT_W+2*LVL_W-1:0] sq_f = (st ? '0 : sumsq) + (CNT_W+2*LVL_W)'(raw * raw);
  wire [CNT_W-1:0] n_f = st ? CNT_W'(1) : n + 1'b1;

  // All detectors update from each beat; first beat reinitializes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pmax <= '0;
      pmin <= '1;
      first_v <= '0;
      got_first <= 1'b0;
      sum <= '0;
      sumsq <= '0;
      n <= '0;
    end else if (beat) begin // R8
      pmax <= (st || lvl > pmax) ? lvl : pmax; // R3 R4 R16
      pmin <= (st || lvl < pmin) ? lvl : pmin; // R3 R4 R16
      first_v <= (st || !got_first) ? lvl : first_v; // R7 R16
      got_first <= 1'b1; // R7
      sum <= sum_f; // R5 R16
      sumsq <= sq_f; // R6 R16
      n <= n_f; // R5 R16
    end
  end

  // Point end: freeze sums and launch arithmetic
  wire end_pt = beat && smp_i.last;
  logic [CNT_W+2*LVL_W-1:0] avg_q;
  logic [CNT_W+2*LVL_W-1:0] msq_q;
  logic avg_done;
  logic msq_done;
  logic [LVL_W-1:0] root;
  logic root_done;
  logic busy;

  tdb_divider #(.NUM_W(CNT_W+2*LVL_W), .DEN_W(CNT_W)) u_avg (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(end_pt && !busy),
    .num_i((CNT_W+2*LVL_W)'(sum_f)), .den_i(n_f), // R5
    .busy_o(), .done_o(avg_done), .quot_o(avg_q));
  tdb_divider #(.NUM_W(CNT_W+2*LVL_W), .DEN_W(CNT_W)) u_msq (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(end_pt && !busy),
    .num_i(sq_f), .den_i(n_f), // R6
    .busy_o(), .done_o(msq_done), .quot_o(msq_q));
  tdb_isqrt #(.IN_W(2*LVL_W)) u_rt (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(msq_done),
    .rad_i(msq_q[2*LVL_W-1:0]), // R6
    .busy_o(), .done_o(root_done), .root_o(root));

  // Hold finished point until results are done
  tdb_pkg::tdb_res_t hold;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      hold <= '0;
      pt_valid_o <= 1'b0;
      pt_res_o <= '0;
      pt_auto_min_o <= '0;
      pt_index_o <= '0;
      point <= '0;
      meas_cnt <= 32'h0000_0000;
    end else begin
      pt_valid_o <= 1'b0;
      if (end_pt && !busy) begin
        busy <= 1'b1;
        hold.pos <= (st || lvl > pmax) ? lvl : pmax;
        hold.neg <= (st || lvl < pmin) ? lvl : pmin; // R2
        hold.smp <= (st || !got_first) ? lvl : first_v;
      end
      if (avg_done) begin
        hold.avg <= avg_q[LVL_W-1:0];
      end
      if (root_done) begin
        busy <= 1'b0;
        pt_valid_o <= 1'b1;
        pt_res_o <= '{pos: hold.pos, neg: hold.neg, avg: hold.avg, rms: root, smp: hold.smp};
        pt_auto_min_o <= hold.neg; // R2
        pt_index_o <= point;
        point <= point + 1'b1;
        meas_cnt <= meas_cnt + 32'h0000_0001;
      end
    end
  end

  // ****************************************************************
  // Trace memory update
  // ****************************************************************
  function automatic logic [LVL_W-1:0] pick(input tdb_pkg::tdb_det_t d,
                                            input tdb_pkg::tdb_res_t r);
    case (d) // R9 R10
      tdb_pkg::DT_AUTO_PEAK, tdb_pkg::DT_POS_PEAK: return r.pos;
      tdb_pkg::DT_NEG_PEAK: return r.neg;
      tdb_pkg::DT_AVERAGE: return r.avg;
      tdb_pkg::DT_RMS: return r.rms;
      default: return r.smp;
    endcase
  endfunction

  // Per-trace: clear on mode change, then store by mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_pend <= '0;
      trace_mem <= '{default: '0};
    end else begin
      for (int t = 0; t < tdb_pkg::TRACES; t++) begin
        logic [2:0] m;
        logic [LVL_W-1:0] v;
        logic [LVL_W-1:0] old;
        m = ctrl[t*3 +: 3];
        v = pick(eff_det(det_cfg[t*3 +: 3], m, 1'b1, auto_sel), pt_res_o);
        old = trace_mem[t][pt_index_o];
        if (bus_wr && wb_adr_i == tdb_pkg::ADDR_CTRL && ctrl_new[t*3 +: 3] != m) begin
          clr_pend[t] <= 1'b1; // R14
          for (int p = 0; p < PTS; p++) begin
            trace_mem[t][p] <= (tdb_pkg::tdb_mode_t'(ctrl_new[t*3 +: 3]) == tdb_pkg::TM_MIN_HOLD)
                               ? '1 : '0; // R14
          end
        end else if (pt_valid_o) begin
          clr_pend[t] <= 1'b0;
          case (tdb_pkg::tdb_mode_t'(m))
            tdb_pkg::TM_CLEAR_WRITE: trace_mem[t][pt_index_o] <= v; // R9
            tdb_pkg::TM_MAX_HOLD: trace_mem[t][pt_index_o] <= (v > old) ? v : old; // R15
            tdb_pkg::TM_MIN_HOLD: trace_mem[t][pt_index_o] <= (v < old) ? v : old;
            tdb_pkg::TM_AVERAGE: trace_mem[t][pt_index_o] <= LVL_W'(({1'b0, v} + {1'b0, old}) >> 1);
            default: trace_mem[t][pt_index_o] <= old;
          endcase
        end
      end
    end
  end

endmodule

// File: verif/tdb_src.sv
`timescale 1ns/1ps
// ****************************************************************
// Envelope sample source standing at the far side of the stream
// ****************************************************************
module tdb_src (
  input wire logic clk_i, // Clock
  output tdb_pkg::tdb_sample_t smp_o, // Sample beat
  output logic [15:0] filt_o // Video-filtered level
);
  initial begin
    smp_o = '0;
    filt_o = 16'h0;
  end

  // Twelve-beat point, then stale data shown inverted
  task automatic send(input logic [15:0] lv [12]);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      smp_o <= {1'b1, i == 0, i == 11, lv[i]};
      filt_o <= lv[i] >> 1;
    end
    @(posedge clk_i);
    smp_o <= {3'b000, ~lv[11]};
    filt_o <= ~(lv[11] >> 1);
  endtask
endmodule

// File: verif/tdb_top_chk.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker
// ****************************************************************
module tdb_top_chk #(
  parameter int LVL_W = 16
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire tdb_pkg::tdb_sample_t smp_i, // Sample beat
  input wire logic pt_valid_o, // Point result pulse
  input wire tdb_pkg::tdb_res_t pt_res_o, // Results
  input wire logic [LVL_W-1:0] pt_auto_min_o // Auto peak minimum
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] since_last;

  // Cycles since the last beat of a point
  always_ff @(posedge clk_i) begin
    if (rst_i) since_last <= 8'hFF;
    else if (smp_i.valid && smp_i.last) since_last <= 8'h00;
    else if (since_last != 8'hFF) since_last <= since_last + 8'h01;
  end

  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");
  property p_pt_pulse; pt_valid_o |=> !pt_valid_o; endproperty
  a_pt_pulse: assert property (p_pt_pulse) else $error("point pulse too long");
  property p_peaks; pt_valid_o |-> pt_res_o.pos >= pt_res_o.neg; endproperty
  a_peaks: assert property (p_peaks) else $error("peak order");
  property p_auto; pt_valid_o |-> pt_auto_min_o == pt_res_o.neg; endproperty
  a_auto: assert property (p_auto) else $error("auto minimum");
  property p_smp; pt_valid_o |-> pt_res_o.smp <= pt_res_o.pos && pt_res_o.smp >= pt_res_o.neg;
  endproperty
  a_smp: assert property (p_smp) else $error("sample outside peaks");
  property p_rms; pt_valid_o |-> pt_res_o.rms >= pt_res_o.avg; endproperty
  a_rms: assert property (p_rms) else $error("rms below mean");
  property p_after; pt_valid_o |-> since_last < 8'hC8; endproperty
  a_after: assert property (p_after) else $error("point without stream");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_point: cover property (pt_valid_o);
endmodule

bind tdb_top tdb_top_chk #(.LVL_W(LVL_W)) tdb_top_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_i(smp_i),
  .pt_valid_o(pt_valid_o), .pt_res_o(pt_res_o), .pt_auto_min_o(pt_auto_min_o)
);

// File: verif/tdb_top_tb_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Testbench
// ****************************************************************
module tdb_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, meas_cycles_o, span_start_o, span_stop_o, level_range_o;
  logic wb_ack_o, vfilt_bypass_o, pt_valid_o, pt_index_o, bypass, pidx;
  tdb_pkg::tdb_sample_t smp_i;
  tdb_pkg::tdb_res_t pt_res_o;
  logic [15:0] filt_level_i, pt_auto_min_o;
  logic [15:0] tr [3][2];
  logic [9:0] ctrl_v;
  logic [17:0] det_v;
  logic [31:0] rd_q [$];
  logic [127:0] pt_q [$];
  int failures = 0;
  int n_compared = 0;
  int n_pts = 0;
  int seed = 32'h41b7ff97;

  tdb_src tdb_src_inst (.clk_i(clk_i), .smp_o(smp_i), .filt_o(filt_level_i));
  tdb_top #(.PTS(2)) tdb_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_i(smp_i), .filt_level_i(filt_level_i),
    .vfilt_bypass_o(vfilt_bypass_o), .meas_cycles_o(meas_cycles_o),
    .span_start_o(span_start_o), .span_stop_o(span_stop_o), .level_range_o(level_range_o),
    .pt_valid_o(pt_valid_o), .pt_index_o(pt_index_o), .pt_res_o(pt_res_o),
    .pt_auto_min_o(pt_auto_min_o)
  );

  // Clock of 50 ns
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Classic bus cycle held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    xfer(1'b0, adr, 32'h0);
  endtask

  task automatic rd_traces;
    for (int t = 0; t < 3; t++)
      for (int p = 0; p < 2; p++) rd(8'(64 + 64 * t + 4 * p), {16'h0, tr[t][p]});
  endtask

  // Mode change clears a trace, min-hold starts full
  task automatic set_ctrl(input logic [9:0] v);
    for (int t = 0; t < 3; t++) if (v[3*t+:3] != ctrl_v[3*t+:3]) begin
      tr[t][0] = (v[3*t+:3] == 3'd3) ? 16'hFFFF : 16'h0;
      tr[t][1] = tr[t][0];
    end
    ctrl_v = v;
    xfer(1'b1, tdb_pkg::ADDR_CTRL, {22'h0, v});
  endtask

  function automatic logic [15:0] isqrt(input logic [31:0] x);
    logic [15:0] r, c;
    r = 16'h0;
    for (int b = 15; b >= 0; b--) begin
      c = r | (16'h1 << b);
      if (32'(c) * 32'(c) <= x) r = c;
    end
    return r;
  endfunction

  // One point: note the expected results, then stream it
  task automatic point;
    logic [15:0] lv [12];
    logic [15:0] f, sm, v, hi = 16'h0, lo = 16'hFFFF;
    logic [31:0] sum = 32'h0;
    logic [39:0] sq = 40'h0;
    logic [79:0] r;
    logic [2:0] d, m;
    int n0;
    for (int i = 0; i < 12; i++) begin
      lv[i] = 16'($random(seed));
      f = bypass ? lv[i] : lv[i] >> 1;
      if (i == 0) sm = f;
      if (f > hi) hi = f;
      if (f < lo) lo = f;
      sum += 32'(lv[i]);
      sq += 40'(lv[i]) * 40'(lv[i]);
    end
    r = {hi, lo, 16'(sum / 12), isqrt(32'(sq / 12)), sm};
    pt_q.push_back(128'({pidx, r, lo}));
    for (int t = 0; t < 3; t++) begin
      m = ctrl_v[3*t+:3];
      d = ctrl_v[9] ? ((m == 3'd4) ? 3'd6 : (m == 3'd5) ? 3'd0 : m) : det_v[3*t+:3];
      v = (d == 3'd3) ? lo : (d == 3'd4) ? r[47:32] : (d == 3'd5) ? r[31:16] : (d == 3'd6) ? sm : hi;
      if (d != 3'd0) begin
        case (m)
          3'd1: tr[t][pidx] = v;
          3'd2: if (v > tr[t][pidx]) tr[t][pidx] = v;
          3'd3: if (v < tr[t][pidx]) tr[t][pidx] = v;
          3'd4: tr[t][pidx] = 16'((17'(tr[t][pidx]) + 17'(v)) >> 1);
          default: ;
        endcase
      end
    end
    n0 = n_pts;
    tdb_src_inst.send(lv);
    for (int i = 0; i < 300 && n_pts == n0; i++) @(posedge clk_i);
    if (n_pts == n0) failures++;
    pidx = ~pidx;
  endtask

  // Each result is matched against the oldest note
  always @(posedge clk_i) begin
    if (!rst_i && wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, rd_q.pop_front());
    if (!rst_i && pt_valid_o === 1'b1) begin
      check({pt_index_o, pt_res_o, pt_auto_min_o}, pt_q.pop_front());
      n_pts++;
    end
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    finish_test();
  end

  // Main sequence
  initial begin
    bypass = 1'b0;
    pidx = 1'b0;
    ctrl_v = 10'h200;
    det_v = 18'h0;
    tr = '{default: 16'h0};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(tdb_pkg::ADDR_CTRL, 32'h200);
    rd(tdb_pkg::ADDR_MEAS_CYC, tdb_pkg::MEAS_CYC_RST);
    xfer(1'b1, 8'h28, 32'h1234);
    rd(8'h28, 32'h0);
    det_v = 18'h358D1;
    xfer(1'b1, tdb_pkg::ADDR_DET, 32'(det_v));
    rd(tdb_pkg::ADDR_DET, 32'(det_v));
    xfer(1'b1, tdb_pkg::ADDR_MEAS_CYC, 32'h5);
    xfer(1'b1, tdb_pkg::ADDR_VFB, 32'h3);
    check(meas_cycles_o, 32'h8);
    xfer(1'b1, tdb_pkg::ADDR_SPAN_START, 32'h100);
    xfer(1'b1, tdb_pkg::ADDR_SPAN_STOP, 32'h900);
    xfer(1'b1, tdb_pkg::ADDR_LEVEL_RANGE, 32'h40);
    check({span_start_o, span_stop_o}, {tdb_pkg::SPAN_START_RST, tdb_pkg::SPAN_STOP_RST});
    xfer(1'b1, tdb_pkg::ADDR_ZOOM, 32'h1);
    @(posedge clk_i);
    check({span_start_o, span_stop_o, level_range_o}, {32'h100, 32'h900, 32'h40});
    set_ctrl(10'h2D1);
    repeat (4) point();
    rd_traces();
    det_v = 18'h358F5;
    xfer(1'b1, tdb_pkg::ADDR_DET, 32'(det_v));
    set_ctrl(10'h163);
    bypass = 1'b1;
    check(vfilt_bypass_o, 1'b1);
    repeat (2) point();
    rd_traces();
    det_v = 18'h358D1;
    xfer(1'b1, tdb_pkg::ADDR_DET, 32'(det_v));
    set_ctrl(10'h344);
    bypass = 1'b0;
    @(posedge clk_i);
    check(vfilt_bypass_o, 1'b0);
    point();
    rd_traces();
    repeat (2) @(posedge clk_i);
    finish_test();
  end
endmodule
